// [src/fpres_classify.sv]
// classifies one register format encoding into a one-hot value class
// assumes a single clock; output registered
`timescale 1ns/100ps
`default_nettype none
module fpres_classify
  import fpres_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire fpres_pkg::fpres_freg_s enc,
  output fpres_pkg::fpres_class_e     cls,
  output logic                        isPseudoZero,
  output logic                        isInf
);

  fpres_class_e clsNext;
  logic         pzNext;

  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    pzNext = (enc.sig == SIG_ZERO) && (enc.exp != EXP_ZERO) && (enc.exp != EXP_SPECIAL) &&
             !((enc.exp == EXP_RFMAX) && !enc.sign);
    if (enc.exp == EXP_SPECIAL)
    begin
      if (!enc.sig[SIG_MSB])
        clsNext = CLS_UNSUP;
      else if (enc.sig == SIG_INT)
        clsNext = CLS_INF;
      else
        clsNext = CLS_NAN;
    end
    else if ((enc.exp == EXP_ZERO) && (enc.sig == SIG_ZERO))
      clsNext = CLS_ZERO;
    else if (enc.sig[SIG_MSB] && (enc.exp != EXP_ZERO))
      clsNext = CLS_NORMAL;
    else
      clsNext = CLS_UNNORM;  // pseudo-zeros land here, never as zero
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cls          <= CLS_ZERO;
      isPseudoZero <= 1'b0;
      isInf        <= 1'b0;
    end
    else
    begin
      cls          <= clsNext;
      isPseudoZero <= pzNext;
      isInf        <= (clsNext == CLS_INF);
    end
  end

  pseudo_zero_unnorm_a: assert property (@(posedge clk) disable iff (!rstn)
    isPseudoZero |-> cls == CLS_UNNORM) else $error("pseudo-zero classed wrongly");

endmodule
`default_nettype wire

// [src/fpres_pkg.sv]
// shared constants and carriers of the fp result shaping and status block
// assumes one core clock; users import fpres_pkg::*
package fpres_pkg;

  // ****************************************
  // register format encoding
  // ****************************************
  typedef struct packed {
    logic        sign;
    logic [16:0] exp;
    logic [63:0] sig;
  } fpres_freg_s;

  localparam logic [16:0] EXP_ZERO    = 17'h00000;
  localparam logic [16:0] EXP_ONE     = 17'h00001;
  localparam logic [16:0] EXP_BIAS    = 17'h0FFFF;
  localparam logic [16:0] EXP_DXMIN   = 17'h0C001;
  localparam logic [16:0] EXP_DXMAX   = 17'h13FFE;
  localparam logic [16:0] EXP_RFMAX   = 17'h1FFFE;
  localparam logic [16:0] EXP_SPECIAL = 17'h1FFFF;
  localparam logic [16:0] EXP_INTEGER = 17'h1003E;
  localparam logic [63:0] SIG_ZERO    = 64'h0000000000000000;
  localparam logic [63:0] SIG_INT     = 64'h8000000000000000;
  localparam logic [63:0] SIG_QNAN    = 64'hC000000000000000;
  localparam logic [63:0] MASK_SGL    = 64'hFFFFFF0000000000;
  localparam logic [63:0] MASK_DBL    = 64'hFFFFFFFFFFFFF800;
  localparam logic [63:0] MASK_EXT    = 64'hFFFFFFFFFFFFFFFF;
  localparam int          SIG_MSB     = 63;
  localparam logic [6:0]  SIG_BITS    = 7'h40;

  localparam fpres_freg_s CONST_ZERO  = '{1'b0, EXP_ZERO, SIG_ZERO};
  localparam fpres_freg_s CONST_ONE   = '{1'b0, EXP_BIAS, SIG_INT};
  localparam fpres_freg_s NAT_TOKEN   = '{1'b0, EXP_RFMAX, SIG_ZERO};
  localparam fpres_freg_s QNAN_INDEF  = '{1'b1, EXP_SPECIAL, SIG_QNAN};
  localparam fpres_freg_s INT_INDEF   = '{1'b0, EXP_INTEGER, SIG_INT};
  localparam logic [6:0]  REG_CZERO   = 7'h00;
  localparam logic [6:0]  REG_CONE    = 7'h01;

  // ****************************************
  // value classes, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    CLS_ZERO   = 6'h01,
    CLS_UNNORM = 6'h02,
    CLS_NORMAL = 6'h04,
    CLS_INF    = 6'h08,
    CLS_NAN    = 6'h10,
    CLS_UNSUP  = 6'h20
  } fpres_class_e;

  // ****************************************
  // status register layout
  // ****************************************
  localparam int TRAP_LSB = 0;
  localparam int SET_W    = 13;
  localparam int SET0_LSB = 6;
  localparam int SET1_LSB = 19;
  localparam int SET2_LSB = 32;
  localparam int SET3_LSB = 45;
  localparam int RSV_LSB  = 58;
  localparam int F_WRE    = 1;
  localparam int F_PC     = 2;
  localparam int F_TD     = 6;
  localparam int F_FLAGS  = 7;
  localparam int EXC_W    = 6;
  localparam int EXC_INV  = 0;
  localparam logic [1:0]  PC_SGL     = 2'h0;
  localparam logic [1:0]  PC_DBL     = 2'h2;
  localparam logic [63:0] STATUS_RST = 64'h0000000000000000;
  localparam logic [63:0] RSV_MASK   = 64'hFC00000000000000;
  localparam logic [63:0] TD0_MASK   = 64'h0000000000001000;

  // ****************************************
  // bus map
  // ****************************************
  localparam logic [31:0] ADDR_STAT_LO = 32'h00000000;
  localparam logic [31:0] ADDR_STAT_HI = 32'h00000004;
  localparam int          ADDR_DEC_W   = 8;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ   = 2'h3;

endpackage

// [src/fpres_top.sv]
// fp result shaping, constant registers and the 64-bit fp status register
// assumes the pipeline presents operands and the raw computed value on the
// same clock; software reaches the status register over ahb-lite
`timescale 1ns/100ps
`default_nettype none
module fpres_top
  import fpres_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  // operation from the pipeline
  input  wire logic                   opValid,
  input  wire logic                   opIsMul,
  input  wire logic [1:0]             opSetSel,
  input  wire logic [6:0]             opDest,
  input  wire fpres_pkg::fpres_freg_s opA,
  input  wire fpres_pkg::fpres_freg_s opB,
  input  wire fpres_pkg::fpres_freg_s opRaw,
  input  wire logic [5:0]             opEvents,
  input  wire logic                   opIntInvalid,
  input  wire logic                   opSpecFail,
  // shaped result and fault
  output logic                        resValid,
  output logic [6:0]                  resDest,
  output fpres_pkg::fpres_freg_s      resData,
  output logic                        faultRaise,
  output logic [5:0]                  faultCause,
  // register file read filter
  input  wire logic [6:0]             rdIdx,
  input  wire fpres_pkg::fpres_freg_s rdRaw,
  output fpres_pkg::fpres_freg_s      rdData,
  // value classification
  input  wire fpres_pkg::fpres_freg_s clsIn,
  output fpres_pkg::fpres_class_e     clsOut
);

  // ****************************************
  // declarations
  // ****************************************
  logic [63:0]  status_reg;
  logic [63:0]  status_next;
  logic         wrPend_reg;
  logic         wrHi_reg;
  logic         addrOk;
  logic         rdTake;
  logic [12:0]  selSet;
  logic [5:0]   effDisable;
  logic [5:0]   evMasked;
  logic [5:0]   evRaise;
  logic         mulSpecial;
  fpres_freg_s  shaped;
  fpres_freg_s  resPick;
  logic         resWrite;
  logic         pzA;
  logic         pzB;
  logic         infA;
  logic         infB;
  fpres_class_e clsA;
  fpres_class_e clsB;
  // stage-1 copies of the operation, aligned with the operand classifiers
  logic         s1Valid_reg;
  logic         s1IsMul_reg;
  logic [1:0]   s1Set_reg;
  logic [6:0]   s1Dest_reg;
  fpres_freg_s  s1Raw_reg;
  logic [5:0]   s1Ev_reg;
  logic         s1IntInv_reg;
  logic         s1Spec_reg;
  logic         s1SignX_reg;

  // ****************************************
  // operand classification
  // ****************************************
  // operands of any encoding pass straight in, no input
  fpres_classify uClsA (.clk(clk), .rstn(rstn), .enc(opA), .cls(clsA),
                        .isPseudoZero(pzA), .isInf(infA));
  fpres_classify uClsB (.clk(clk), .rstn(rstn), .enc(opB), .cls(clsB),
                        .isPseudoZero(pzB), .isInf(infB));
  fpres_classify uClsO (.clk(clk), .rstn(rstn), .enc(clsIn), .cls(clsOut),
                        .isPseudoZero(), .isInf());

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1Valid_reg  <= 1'b0;
      s1IsMul_reg  <= 1'b0;
      s1Set_reg    <= 2'h0;
      s1Dest_reg   <= 7'h00;
      s1Raw_reg    <= CONST_ZERO;
      s1Ev_reg     <= 6'h00;
      s1IntInv_reg <= 1'b0;
      s1Spec_reg   <= 1'b0;
      s1SignX_reg  <= 1'b0;
    end
    else
    begin
      s1Valid_reg  <= opValid;
      s1IsMul_reg  <= opIsMul;
      s1Set_reg    <= opSetSel;
      s1Dest_reg   <= opDest;
      s1Raw_reg    <= opRaw;
      s1Ev_reg     <= opEvents;
      s1IntInv_reg <= opIntInvalid;
      s1Spec_reg   <= opSpecFail;
      s1SignX_reg  <= opA.sign ^ opB.sign;
    end
  end

  // ****************************************
  // trap enables
  // ****************************************
  always_comb
  begin
    case (s1Set_reg)
      2'h0:    selSet = status_reg[SET0_LSB +: SET_W];
      2'h1:    selSet = status_reg[SET1_LSB +: SET_W];
      2'h2:    selSet = status_reg[SET2_LSB +: SET_W];
      default: selSet = status_reg[SET3_LSB +: SET_W];
    endcase
    // override forces every disable on for this set
    effDisable = selSet[F_TD] ? '1 : status_reg[TRAP_LSB +: EXC_W];
  end

  // zero-like pseudo-zero times infinity: infinity, invalid suppressed
  assign mulSpecial = s1IsMul_reg && ((pzA && infB) || (pzB && infA));
  assign evMasked   = mulSpecial ? (s1Ev_reg & ~(6'h01 << EXC_INV)) : s1Ev_reg;
  // only enabled exceptions of an executing op fault
  assign evRaise    = s1Valid_reg ? (evMasked & ~effDisable) : 6'h00;

  // ****************************************
  // result shaping
  // ****************************************
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    n = SIG_BITS;
    for (int k = 0; k <= SIG_MSB; k++)
      if (v[k])
        n = 7'(SIG_MSB - k);
    return n;
  endfunction

  always_comb
  begin
    logic [16:0] e;
    logic [63:0] s;
    logic [16:0] sh;
    logic [16:0] eMin;
    logic [16:0] eMax;
    logic [63:0] pMask;
    pMask = MASK_EXT;
    e     = s1Raw_reg.exp;
    s     = s1Raw_reg.sig;
    sh    = '0;
    eMin  = selSet[F_WRE] ? EXP_ONE : EXP_DXMIN;
    eMax  = selSet[F_WRE] ? EXP_RFMAX : EXP_DXMAX;
    case (selSet[F_PC +: 2])
      PC_SGL:  pMask = MASK_SGL;
      PC_DBL:  pMask = MASK_DBL;
      default: pMask = MASK_EXT;
    endcase
    if (e == EXP_SPECIAL)
      s[SIG_MSB] = 1'b1;              // no pseudo-nan or pseudo-infinity out
    else if (s == SIG_ZERO)
      e = EXP_ZERO;                   // one zero encoding, never pseudo-zero
    else
    begin
      if (e == EXP_ZERO)
        e = EXP_ONE;                  // same scale; also retires pseudo-denormals
      sh = {10'h000, lead_zeros(s)};
      if (sh > e - EXP_ONE)
        sh = e - EXP_ONE;
      s = s << sh;
      e = e - sh;
      if (e > eMax)
      begin
        e = EXP_SPECIAL;              // overflow to the unique infinity
        s = SIG_INT;
      end
      else
      begin
        if (e < eMin)
        begin
          sh = eMin - e;
          s  = (sh >= {10'h000, SIG_BITS}) ? SIG_ZERO : (s >> sh);
          e  = eMin;
        end
        s = s & pMask;                // truncation only: rounding lives upstream
        if (s == SIG_ZERO)
          e = EXP_ZERO;
        else if (!s[SIG_MSB] && (e == EXP_DXMIN))
          e = EXP_ZERO;
      end
    end
    shaped = '{s1Raw_reg.sign, e, s};
  end

  always_comb
  begin
    resWrite = s1Valid_reg;
    if (s1Spec_reg)
      resPick = NAT_TOKEN;
    else if (mulSpecial)
      resPick = '{s1SignX_reg, EXP_SPECIAL, SIG_INT};
    else if (evMasked[EXC_INV] && effDisable[EXC_INV])
      resPick = QNAN_INDEF;
    else if (s1IntInv_reg && effDisable[EXC_INV])
      resPick = INT_INDEF;
    else
      resPick = shaped;
    if (s1IntInv_reg && !effDisable[EXC_INV] && !s1Spec_reg)
      resWrite = 1'b0;
    if ((evRaise != 6'h00) && !s1Spec_reg)
      resWrite = 1'b0;                // a faulting op leaves its target alone
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      resValid   <= 1'b0;
      resDest    <= 7'h00;
      resData    <= CONST_ZERO;
      faultRaise <= 1'b0;
      faultCause <= 6'h00;
    end
    else
    begin
      resValid   <= resWrite;
      resDest    <= s1Dest_reg;
      resData    <= resPick;
      faultRaise <= !s1Spec_reg && ((evRaise != 6'h00) ||
                    (s1Valid_reg && s1IntInv_reg && !effDisable[EXC_INV]));
      faultCause <= s1Spec_reg ? 6'h00 :
                    (evRaise | ((s1Valid_reg && s1IntInv_reg && !effDisable[EXC_INV]) ?
                    6'h01 : 6'h00));
    end
  end

  // ****************************************
  // constant registers on read
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdData <= CONST_ZERO;
    else if (rdIdx == REG_CZERO)
      rdData <= CONST_ZERO;
    else if (rdIdx == REG_CONE)
      rdData <= CONST_ONE;
    else
      rdData <= rdRaw;
  end

  // ****************************************
  // status register and ahb-lite slave
  // ****************************************
  // zero wait states; the unmapped space reads zero and ignores writes
  assign addrOk = (haddr[ADDR_DEC_W-1:0] == ADDR_STAT_LO[ADDR_DEC_W-1:0]) ||
                  (haddr[ADDR_DEC_W-1:0] == ADDR_STAT_HI[ADDR_DEC_W-1:0]);
  assign rdTake = hsel && hready && !hwrite && htrans[1];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_reg <= 1'b0;
      wrHi_reg   <= 1'b0;
    end
    else if (hready)
    begin
      wrPend_reg <= hsel && hwrite && htrans[1] && addrOk;
      wrHi_reg   <= haddr[2];
    end
  end

  always_comb
  begin
    status_next = status_reg;
    if (wrPend_reg)
    begin
      if (wrHi_reg)
        status_next[63:32] = hwdata;
      else
        status_next[31:0] = hwdata;
    end
    // flags are plain storage: software writes never fault
    // hardware events are ORed last so a set beats a same-cycle clear
    if (s1Valid_reg && !s1Spec_reg)
    begin
      case (s1Set_reg)
        2'h0:    status_next[SET0_LSB+F_FLAGS +: EXC_W] |= evMasked;
        2'h1:    status_next[SET1_LSB+F_FLAGS +: EXC_W] |= evMasked;
        2'h2:    status_next[SET2_LSB+F_FLAGS +: EXC_W] |= evMasked;
        default: status_next[SET3_LSB+F_FLAGS +: EXC_W] |= evMasked;
      endcase
    end
    status_next = status_next & ~RSV_MASK & ~TD0_MASK;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_reg <= STATUS_RST;
    else
      status_reg <= status_next;
  end

  // read data follows any write in flight, so write-then-read sees new data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (rdTake)
      hrdata <= !addrOk ? 32'h00000000 : (haddr[2] ? status_next[63:32] : status_next[31:0]);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  rsv_bits_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (status_reg & RSV_MASK) == 64'h0) else $error("reserved bits set");
  main_td_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    !status_reg[SET0_LSB+F_TD]) else $error("main set override bit set");
  const_regs_a: assert property (@(posedge clk) disable iff (!rstn)
    rdIdx == REG_CONE |=> rdData == CONST_ONE) else $error("register one wrong");
  nat_token_a: assert property (@(posedge clk) disable iff (!rstn)
    opValid && opSpecFail ##1 1'b1 |=> resValid && resData == NAT_TOKEN)
    else $error("token not written");
  no_pseudo_out_a: assert property (@(posedge clk) disable iff (!rstn)
    resValid && resData.exp != EXP_RFMAX |-> resData.sig[SIG_MSB] ||
    (resData.exp == EXP_ZERO) || (resData.exp == EXP_ONE && !selSet[F_WRE]) ||
    (resData.exp == EXP_ONE)) else $error("pseudo encoding produced");
  dx_denorm_exp_a: assert property (@(posedge clk) disable iff (!rstn)
    resValid && resData.exp == EXP_DXMIN |-> resData.sig[SIG_MSB])
    else $error("denormal at alternate exponent");
  pz_mul_inf_a: assert property (@(posedge clk) disable iff (!rstn)
    mulSpecial && s1Valid_reg && !s1Spec_reg |=> resData.exp == EXP_SPECIAL &&
    resData.sig == SIG_INT && !faultCause[EXC_INV]) else $error("pz times inf wrong");
  override_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    selSet[F_TD] |=> !faultRaise) else $error("override ignored");
  sticky_set_a: assert property (@(posedge clk) disable iff (!rstn)
    s1Valid_reg && !s1Spec_reg && s1Set_reg == 2'h1 && evMasked[0] |=>
    status_reg[SET1_LSB+F_FLAGS]) else $error("flag not set");
  masked_inv_a: assert property (@(posedge clk) disable iff (!rstn)
    s1Valid_reg && !s1Spec_reg && !mulSpecial && evMasked[EXC_INV] && effDisable[EXC_INV]
    |=> resValid && resData == QNAN_INDEF) else $error("no qnan indefinite");

  cov_fault_c:  cover property (@(posedge clk) disable iff (!rstn) faultRaise);
  cov_pzmul_c:  cover property (@(posedge clk) disable iff (!rstn) mulSpecial && s1Valid_reg);
  cov_wr_rd_c:  cover property (@(posedge clk) disable iff (!rstn) wrPend_reg && rdTake);

endmodule
`default_nettype wire

// [verification/fp_result_encoding_status_test.sv]
// self-checking bench of the fp result shaping and status block
// assumes fpres_top and the pipeline stand-in; one 10 MHz clock
`timescale 1ns/100ps
`default_nettype none
module fp_result_encoding_status_test;
  import fpres_pkg::*;
  localparam fpres_freg_s PZ   = '{1'b0, 17'h00005, SIG_ZERO};
  localparam fpres_freg_s INF  = '{1'b0, EXP_SPECIAL, SIG_INT};
  localparam fpres_freg_s HALF = '{1'b0, EXP_BIAS, 64'h4000000000000000};
  localparam fpres_freg_s HNRM = '{1'b0, 17'h0FFFE, SIG_INT};
  localparam fpres_freg_s DRAW = '{1'b0, EXP_DXMIN, 64'h4000000000000000};
  localparam fpres_freg_s DEXP = '{1'b0, EXP_ZERO, 64'h4000000000000000};
  localparam fpres_freg_s ZRAW = '{1'b1, 17'h01234, SIG_ZERO};
  localparam fpres_freg_s ZEXP = '{1'b1, EXP_ZERO, SIG_ZERO};
  localparam fpres_freg_s TINY = '{1'b1, 17'h00010, SIG_INT};
  localparam fpres_freg_s ONES = '{1'b0, EXP_BIAS, 64'hFFFFFFFFFFFFFFFF};
  localparam fpres_freg_s ODBL = '{1'b0, EXP_BIAS, 64'hFFFFFFFFFFFFF800};
  localparam fpres_freg_s OSGL = '{1'b0, EXP_BIAS, 64'hFFFFFF0000000000};
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [1:0]   htrans = 2'h0;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic         hready, hreadyout, hresp, resValid, faultRaise;
  logic         opValid, opIsMul, opIntInvalid, opSpecFail;
  logic [1:0]   opSetSel;
  logic [6:0]   opDest, resDest;
  logic [6:0]   rdIdx = 7'h00;
  logic [5:0]   opEvents, faultCause;
  fpres_freg_s  opA, opB, opRaw, resData, rdData;
  fpres_freg_s  rdRaw = INF;
  fpres_freg_s  clsIn = PZ;
  fpres_class_e clsOut;
  int           errCount = 0, totalChecks = 0, faultCnt = 0;
  assign hready = hreadyout;
  always #50 clk = ~clk;
  always @(posedge clk) if (faultRaise === 1'b1) faultCnt++;

  fpres_pipe_model i_pipe (.clk(clk), .opValid(opValid), .opIsMul(opIsMul), .opSetSel(opSetSel),
    .opDest(opDest), .opA(opA), .opB(opB), .opRaw(opRaw), .opEvents(opEvents),
    .opIntInvalid(opIntInvalid), .opSpecFail(opSpecFail));
  fpres_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .opValid(opValid), .opIsMul(opIsMul), .opSetSel(opSetSel),
    .opDest(opDest), .opA(opA), .opB(opB), .opRaw(opRaw), .opEvents(opEvents),
    .opIntInvalid(opIntInvalid), .opSpecFail(opSpecFail), .resValid(resValid),
    .resDest(resDest), .resData(resData), .faultRaise(faultRaise), .faultCause(faultCause),
    .rdIdx(rdIdx), .rdRaw(rdRaw), .rdData(rdData), .clsIn(clsIn), .clsOut(clsOut));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input string n, input logic [81:0] e, input logic [81:0] g);
    totalChecks++;
    if (g !== e)
    begin
      errCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 82'h0, hresp);
  endtask
  task automatic run(input logic m, input logic [1:0] s, input fpres_freg_s a, b, r,
                     input logic [5:0] e, input logic ii, sf, ev, input fpres_freg_s ed,
                     input logic ef);
    i_pipe.issue(m, s, a, b, r, e, ii, sf);
    // result registers load one edge after the taking edge and stand one cycle
    @(posedge clk);
    @(negedge clk);
    chk("resValid", ev, resValid);
    chk("faultRaise", ef, faultRaise);
    if (ev) chk("resData", ed, resData);
    if (ev) chk("resDest", 82'h0A, resDest);
    if (ef) chk("faultCause", e, faultCause);
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, ADDR_STAT_LO, 32'h0);
    chk("stat_lo", 82'h0, rd);
    bus(1, ADDR_STAT_LO, 32'hFFFFFFFF);
    bus(1, ADDR_STAT_HI, 32'hFFFFFFFF);
    bus(0, ADDR_STAT_LO, 32'h0);
    chk("stat_lo", 32'hFFFFEFFF, rd);
    bus(0, ADDR_STAT_HI, 32'h0);
    chk("stat_hi", 32'h03FFFFFF, rd);
    bus(0, 32'h00000008, 32'h0);
    chk("unmapped", 82'h0, rd);
    chk("faults", 82'h0, faultCnt);
    $display("register test done");
    // main set: extended precision, narrow range, traps on; alt set one overridden
    // alt set two: wide range, double precision; alt set three: narrow, single
    bus(1, ADDR_STAT_LO, 32'h02000300);
    bus(1, ADDR_STAT_HI, 32'h0000000A);
    run(0, 2'h2, INF, PZ, TINY, 6'h00, 0, 0, 1, TINY, 0);
    run(0, 2'h2, INF, PZ, ONES, 6'h00, 0, 0, 1, ODBL, 0);
    run(0, 2'h3, INF, PZ, ONES, 6'h00, 0, 0, 1, OSGL, 0);
    run(0, 2'h0, PZ, INF, HALF, 6'h00, 0, 0, 1, HNRM, 0);
    run(0, 2'h0, PZ, INF, DRAW, 6'h00, 0, 0, 1, DEXP, 0);
    run(0, 2'h0, PZ, PZ, ZRAW, 6'h00, 0, 0, 1, ZEXP, 0);
    run(0, 2'h0, INF, PZ, HALF, 6'h00, 0, 1, 1, NAT_TOKEN, 0);
    run(0, 2'h0, INF, PZ, HALF, 6'h01, 0, 0, 0, HALF, 1);
    run(0, 2'h1, INF, PZ, HALF, 6'h01, 0, 0, 1, QNAN_INDEF, 0);
    bus(0, ADDR_STAT_LO, 32'h0);
    chk("flags", 32'h06002300, rd);
    run(0, 2'h1, INF, PZ, HALF, 6'h00, 1, 0, 1, INT_INDEF, 0);
    run(1, 2'h0, PZ, INF, HALF, 6'h01, 0, 0, 1, INF, 0);
    $display("operation test done");
    for (int i = 0; i < 3; i++)
    begin
      rdIdx <= i[6:0];
      @(posedge clk);
      @(negedge clk);
      chk("rdData", (i == 0) ? CONST_ZERO : (i == 1) ? CONST_ONE : INF, rdData);
      @(posedge clk);
    end
    clsIn <= '0;
    @(posedge clk);
    @(negedge clk);
    chk("clsZero", CLS_ZERO, clsOut);
    clsIn <= PZ;
    @(posedge clk);
    @(negedge clk);
    chk("clsPz", CLS_UNNORM, clsOut);
    $display("read and class test done");
    summarize();
  end
  initial
  begin
    #(2000 * 100);
    errCount++;
    summarize();
  end
endmodule
`default_nettype wire

// [verification/fpres_pipe_model.sv]
// pipeline stand-in: presents one operation to the result stage
// assumes issue is called right after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module fpres_pipe_model
  import fpres_pkg::*;
(
  input  wire logic              clk,
  output logic                   opValid,
  output logic                   opIsMul,
  output logic [1:0]             opSetSel,
  output logic [6:0]             opDest,
  output fpres_pkg::fpres_freg_s opA,
  output fpres_pkg::fpres_freg_s opB,
  output fpres_pkg::fpres_freg_s opRaw,
  output logic [5:0]             opEvents,
  output logic                   opIntInvalid,
  output logic                   opSpecFail
);
  initial {opValid, opIsMul, opSetSel, opDest, opA, opB, opRaw} = '0;
  initial {opEvents, opIntInvalid, opSpecFail} = '0;
  // any encoding, pseudo and unsupported too, is offered as an operand
  task automatic issue(input logic m, input logic [1:0] s, input fpres_freg_s a, b, r,
                       input logic [5:0] e, input logic ii, input logic sf);
    opValid <= 1'b1;
    opIsMul <= m;
    opSetSel <= s;
    opDest <= 7'h0A;
    opA <= a;
    opB <= b;
    opRaw <= r;
    opEvents <= e;
    opIntInvalid <= ii;
    opSpecFail <= sf;
    @(posedge clk);
    // stale operand lines are inverted so nothing leans on old values
    opValid <= 1'b0;
    opA <= ~a;
    opB <= ~b;
    opRaw <= ~r;
  endtask
endmodule
`default_nettype wire
